// >>> include/sca_pkg.sv
// Purpose: Shared constants and types for the storage card command block
// Assumes: 250 MHz system clock
// Notes:   Times are kept in their own unit; cycle counts derive from them
package sca_pkg;
	// ==========================================================
	// Clock and timing
	localparam int unsigned CLK_PERIOD_NS     = 4;
	localparam int unsigned IDLE_STEP_NS      = 5000000;
	localparam int unsigned IDLE_STEP_CYC     = IDLE_STEP_NS / CLK_PERIOD_NS;
	localparam int unsigned WAIT_MAX_STOR_NS  = 350;
	localparam int unsigned WAIT_MAX_STOR_CYC = WAIT_MAX_STOR_NS / CLK_PERIOD_NS;
	localparam int unsigned WAIT_MAX_PLUS_NS  = 3000;
	localparam int unsigned WAIT_MAX_PLUS_CYC = WAIT_MAX_PLUS_NS / CLK_PERIOD_NS;
	localparam int unsigned WAIT_CNT_W        = 10;
	localparam int unsigned IDLE_STEP_W       = 21;

	// ==========================================================
	// Configuration space
	localparam logic [11:0] CFG_BASE_STORAGE  = 12'h200;
	localparam logic [7:0]  HOST_CURRENT_RST  = 8'h00;

	// ==========================================================
	// Feature sub-codes
	localparam logic [7:0] FEAT_XFER_MODE  = 8'h03;
	localparam logic [7:0] FEAT_ECC_LEN    = 8'h44;
	localparam logic [7:0] FEAT_LOOKAHEAD  = 8'haa;
	localparam logic [7:0] FEAT_COMPAT_A   = 8'h69;
	localparam logic [7:0] FEAT_COMPAT_B   = 8'h96;
	localparam logic [7:0] FEAT_COMPAT_C   = 8'h97;
	localparam logic [7:0] FEAT_HOST_CURR  = 8'h9a;

	// ==========================================================
	// Extra opcodes
	localparam logic [7:0] OPC_ERASE       = 8'hc0;
	localparam logic [7:0] OPC_TRANSLATE   = 8'h87;
	localparam logic [7:0] OPC_WEAR_LEVEL  = 8'hf5;
	localparam logic [7:0] OPC_SENSE       = 8'h03;
	localparam logic [7:0] OPC_WR_NOERASE  = 8'h38;
	localparam logic [7:0] OPC_WRM_NOERASE = 8'hcd;

	typedef enum logic [2:0] {
		OP_BASELINE    = 3'b000,
		OP_ERASE       = 3'b001,
		OP_TRANSLATE   = 3'b010,
		OP_WEAR_LEVEL  = 3'b011,
		OP_SENSE       = 3'b100,
		OP_WR_NOERASE  = 3'b101,
		OP_WRM_NOERASE = 3'b110
	} sca_op_t;

	typedef enum logic [1:0] {
		MODE_MEMORY      = 2'b00,
		MODE_IO          = 2'b01,
		MODE_DIRECT_DISK = 2'b10
	} sca_mode_t;

	typedef enum logic [1:0] {
		ST_READY = 2'b00,
		ST_EXEC  = 2'b01,
		ST_SLEEP = 2'b10
	} sca_state_t;

	typedef struct packed {
		logic [7:0] opcode;
		logic [7:0] feature;
		logic [7:0] count;
	} sca_cmd_t;

	typedef struct packed {
		logic done;
		logic aborted;
	} sca_rsp_t;
endpackage : sca_pkg

// >>> core/sca_core.sv
// Purpose: Command decode, feature handling, idle timer and wait limit
// Assumes: Command side logic shares clk_sys; mode strap arrives from a pin
// Notes:   Baseline commands pass to the backend unchanged

// Notes on behaviour
// [R1] Abort transfer-mode, ECC-length, look-ahead features
// [R2] Accept three legacy features with no effect
// [R3] Record host current capability and respect it
// [R4] Decode erase, translate and wear-level opcodes
// [R5] Decode sense and no-erase write opcodes
// [R6] Idle timer unit equals 5 ms
// [R7] Any command wakes the card from sleep
// [R8] Storage card config registers at 200h
// [R9] Non-storage card reports its config base
// [R10] Wait limited to 350 ns or 3 us
// [R11] Access modes required by card class
// [R12] Power level 1 makes a non-storage card
// [R13] Unknown feature sub-codes end aborted
module sca_core #(
	parameter int unsigned  IDLE_STEP     = sca_pkg::IDLE_STEP_CYC,
	parameter logic [7:0]   SET_FEAT_OPC  = 8'hef,
	parameter bit           STORAGE_CARD  = 1'b1,
	parameter bit           DISK_OPTIONAL = 1'b0,
	parameter logic [11:0]  PLUS_CFG_BASE = 12'h400,
	parameter logic [7:0]   LVL1_MIN_CURR = 8'h01
) (
	input  wire logic              clk_sys,
	input  wire logic              reset_n,
	input  wire logic              ce,
	input  wire sca_pkg::sca_cmd_t cmd_in,
	input  wire logic              cmd_valid,
	output logic                   cmd_ready,
	output logic                   exec_valid,
	output sca_pkg::sca_op_t       exec_op,
	output sca_pkg::sca_cmd_t      exec_cmd,
	input  wire logic              exec_done,
	input  wire logic              exec_error,
	input  wire logic              sleep_enter,
	output sca_pkg::sca_rsp_t      rsp,
	output logic                   asleep,
	input  wire logic              idle_load,
	input  wire logic [7:0]        idle_units,
	output logic                   standby_req,
	input  wire logic              wait_req,
	output logic                   wait_n,
	output logic                   wait_cut,
	input  wire logic              lvl1_cfg_req,
	output logic [7:0]             host_current,
	output logic                   lvl1_active,
	output logic                   card_nonstorage,
	output logic [11:0]            cfg_base,
	input  wire logic [1:0]        mode_pin,
	output logic                   mode_ok
);
	import sca_pkg::*;

	// ==========================================================
	// Decode helpers
	function automatic sca_op_t decode_op(input logic [7:0] opc);
		sca_op_t op;
		op = OP_BASELINE;
		case (opc)
			OPC_ERASE:       op = OP_ERASE;       // [R4]
			OPC_TRANSLATE:   op = OP_TRANSLATE;   // [R4]
			OPC_WEAR_LEVEL:  op = OP_WEAR_LEVEL;  // [R4]
			OPC_SENSE:       op = OP_SENSE;       // [R5]
			OPC_WR_NOERASE:  op = OP_WR_NOERASE;  // [R5]
			OPC_WRM_NOERASE: op = OP_WRM_NOERASE; // [R5]
			default:         op = OP_BASELINE;
		endcase
		return op;
	endfunction : decode_op

	// Only the legacy and host-current codes are known; all else aborts
	function automatic logic feature_known(input logic [7:0] feat);
		logic ok;
		ok = 1'b0;
		case (feat)
			FEAT_COMPAT_A:  ok = 1'b1; // [R2]
			FEAT_COMPAT_B:  ok = 1'b1; // [R2]
			FEAT_COMPAT_C:  ok = 1'b1; // [R2]
			FEAT_HOST_CURR: ok = 1'b1; // [R3]
			FEAT_XFER_MODE: ok = 1'b0; // [R1]
			FEAT_ECC_LEN:   ok = 1'b0; // [R1]
			FEAT_LOOKAHEAD: ok = 1'b0; // [R1]
			default:        ok = 1'b0; // [R13]
		endcase
		return ok;
	endfunction : feature_known

	// ==========================================================
	// Command acceptance
	sca_state_t state_q;
	sca_state_t state_d;
	logic       take;
	logic       is_feat;
	logic       feat_ok;

	assign is_feat   = (cmd_in.opcode == SET_FEAT_OPC);
	assign feat_ok   = feature_known(cmd_in.feature);
	assign cmd_ready = (state_q != ST_EXEC);
	assign take      = ce && cmd_valid && cmd_ready;
	assign asleep    = (state_q == ST_SLEEP);

	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_READY: begin
				if (cmd_valid && !is_feat) begin
					state_d = ST_EXEC;
				end else if (!cmd_valid && sleep_enter) begin
					state_d = ST_SLEEP;
				end
			end
			ST_EXEC: begin
				if (exec_done) begin
					state_d = ST_READY;
				end
			end
			ST_SLEEP: begin
				// No reset needed: the next command itself is run
				if (cmd_valid) begin // [R7]
					state_d = is_feat ? ST_READY : ST_EXEC; // [R7]
				end
			end
			default: state_d = ST_READY;
		endcase
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= ST_READY;
		end else if (ce) begin
			state_q <= state_d;
		end
	end

	// ==========================================================
	// Backend hand-off
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			exec_valid <= 1'b0;
			exec_op    <= OP_BASELINE;
			exec_cmd   <= '0;
		end else if (ce) begin
			exec_valid <= take && !is_feat;
			if (take && !is_feat) begin
				exec_op  <= decode_op(cmd_in.opcode); // [R4] [R5]
				exec_cmd <= cmd_in;
			end
		end
	end

	// ==========================================================
	// Completion
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			rsp <= '0;
		end else if (ce) begin
			if (take && is_feat) begin
				rsp.done    <= 1'b1;
				rsp.aborted <= !feat_ok; // [R1] [R13]
			end else if (state_q == ST_EXEC && exec_done) begin
				rsp.done    <= 1'b1;
				rsp.aborted <= exec_error;
			end else begin
				rsp <= '0;
			end
		end
	end

	// ==========================================================
	// Host current capability and power level 1
	logic [7:0] host_curr_q;

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			host_curr_q <= HOST_CURRENT_RST;
		end else if (ce) begin
			if (take && is_feat && cmd_in.feature == FEAT_HOST_CURR) begin
				host_curr_q <= cmd_in.count; // [R3]
			end
		end
	end

	assign host_current = host_curr_q;

	// Level 1 only when the host said it can source enough current
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			lvl1_active <= 1'b0;
		end else if (ce) begin
			lvl1_active <= lvl1_cfg_req && (host_curr_q >= LVL1_MIN_CURR); // [R3]
		end
	end

	// A storage build turns non-storage one cycle after level 1 comes into use
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			card_nonstorage <= !STORAGE_CARD;
		end else if (ce) begin
			card_nonstorage <= !STORAGE_CARD || lvl1_active; // [R12]
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			cfg_base <= CFG_BASE_STORAGE;
		end else if (ce) begin
			cfg_base <= card_nonstorage ? PLUS_CFG_BASE : CFG_BASE_STORAGE; // [R8] [R9]
		end
	end

	// ==========================================================
	// Access mode check
	logic [1:0] mode_meta_q;
	logic [1:0] mode_sync_q;

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			mode_meta_q <= 2'h0;
			mode_sync_q <= 2'h0;
		end else if (ce) begin
			mode_meta_q <= mode_pin;
			mode_sync_q <= mode_meta_q;
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			mode_ok <= 1'b0;
		end else if (ce) begin
			case (mode_sync_q)
				MODE_MEMORY:      mode_ok <= 1'b1; // [R11]
				MODE_IO:          mode_ok <= 1'b1; // [R11]
				MODE_DIRECT_DISK: mode_ok <= !card_nonstorage || !DISK_OPTIONAL; // [R11]
				default:          mode_ok <= 1'b0;
			endcase
		end
	end

	// ==========================================================
	// Idle timer: units of one step each, zero disables
	logic [IDLE_STEP_W-1:0] step_q;
	logic [7:0]             units_q;
	logic [7:0]             left_q;
	logic                   step_end;

	assign step_end = (step_q == IDLE_STEP_W'(IDLE_STEP - 1)); // [R6]

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			units_q <= 8'h00;
		end else if (ce && idle_load) begin
			units_q <= idle_units;
		end
	end

	// Any command restarts the countdown, so a busy card never idles out
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			step_q      <= '0;
			left_q      <= 8'h00;
			standby_req <= 1'b0;
		end else if (ce) begin
			standby_req <= 1'b0;
			if (idle_load || take || state_q != ST_READY) begin
				step_q <= '0;
				left_q <= idle_load ? idle_units : units_q;
			end else if (left_q != 8'h00) begin
				if (step_end) begin // [R6]
					step_q <= '0;
					left_q <= left_q - 8'h01;
					standby_req <= (left_q == 8'h01);
				end else begin
					step_q <= step_q + IDLE_STEP_W'(1);
				end
			end
		end
	end

	// ==========================================================
	// Wait limiter
	logic [WAIT_CNT_W-1:0] wait_cnt_q;
	logic [WAIT_CNT_W-1:0] wait_lim;
	logic                  wait_q;

	assign wait_lim = card_nonstorage ? WAIT_CNT_W'(WAIT_MAX_PLUS_CYC)
	                                  : WAIT_CNT_W'(WAIT_MAX_STOR_CYC); // [R10]

	// Cut-off holds until the request drops, trading data for bus timing
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			wait_q     <= 1'b0;
			wait_cut   <= 1'b0;
			wait_cnt_q <= '0;
		end else if (ce) begin
			if (!wait_req) begin
				wait_q     <= 1'b0;
				wait_cut   <= 1'b0;
				wait_cnt_q <= '0;
			end else if (wait_cut || (wait_q && wait_cnt_q >= wait_lim - 1'b1)) begin
				wait_q   <= 1'b0; // [R10]
				wait_cut <= 1'b1;
			end else begin
				wait_q     <= 1'b1;
				wait_cnt_q <= wait_q ? wait_cnt_q + 1'b1 : WAIT_CNT_W'(1);
			end
		end
	end

	assign wait_n = !wait_q;
endmodule : sca_core

// >>> sim/sca_sva.sv
// Purpose: Port-level checks for the storage card command block
// Assumes: Single clock domain; command checks require ce
// Notes:   Wait limit follows the live card class
module sca_sva
	import sca_pkg::*;
#(
	parameter logic [7:0] SET_FEAT_OPC = 8'hef
) (
	input wire logic        clk_sys,
	input wire logic        reset_n,
	input wire logic        ce,
	input wire sca_cmd_t    cmd_in,
	input wire logic        cmd_valid,
	input wire logic        cmd_ready,
	input wire logic        exec_valid,
	input wire sca_op_t     exec_op,
	input wire sca_rsp_t    rsp,
	input wire logic        asleep,
	input wire logic        wait_n,
	input wire logic [7:0]  host_current,
	input wire logic        lvl1_active,
	input wire logic        card_nonstorage,
	input wire logic [11:0] cfg_base
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================================
	// Helpers
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	logic       take;
	logic       feat;
	logic [9:0] wcnt_q;
	assign take = ce && cmd_valid && cmd_ready;
	assign feat = take && cmd_in.opcode == SET_FEAT_OPC;
	function automatic sca_op_t exp_op(input logic [7:0] o);
		case (o)
			8'hc0: exp_op = OP_ERASE;
			8'h87: exp_op = OP_TRANSLATE;
			8'hf5: exp_op = OP_WEAR_LEVEL;
			8'h03: exp_op = OP_SENSE;
			8'h38: exp_op = OP_WR_NOERASE;
			8'hcd: exp_op = OP_WRM_NOERASE;
			default: exp_op = OP_BASELINE;
		endcase
	endfunction : exp_op
	// Saturates so a stuck wait cannot wrap back under the limit
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) wcnt_q <= 10'h000;
		else if (wait_n) wcnt_q <= 10'h000;
		else if (wcnt_q != 10'h3ff) wcnt_q <= wcnt_q + 10'h001;
	end

	// ==========================================================
	// Properties
	property p_feat_bad;
		feat && !(cmd_in.feature inside {8'h69, 8'h96, 8'h97, 8'h9a}) |=> rsp.done && rsp.aborted;
	endproperty
	a_feat_bad: assert property (p_feat_bad) else $error("bad feature not aborted");
	property p_feat_ok;
		feat && cmd_in.feature inside {8'h69, 8'h96, 8'h97, 8'h9a} |=> rsp.done && !rsp.aborted;
	endproperty
	a_feat_ok: assert property (p_feat_ok) else $error("accepted feature failed");
	property p_host_curr;
		feat && cmd_in.feature == 8'h9a |=> host_current == $past(cmd_in.count);
	endproperty
	a_host_curr: assert property (p_host_curr) else $error("host current not kept");
	property p_exec_map;
		take && cmd_in.opcode != SET_FEAT_OPC
			|=> exec_valid && exec_op == exp_op($past(cmd_in.opcode)) && !cmd_ready;
	endproperty
	a_exec_map: assert property (p_exec_map) else $error("opcode decode wrong");
	property p_wake;
		asleep && take |=> !asleep;
	endproperty
	a_wake: assert property (p_wake) else $error("no wake on command");
	property p_cfg_base;
		!card_nonstorage [*2] |-> cfg_base == 12'h200;
	endproperty
	a_cfg_base: assert property (p_cfg_base) else $error("config base wrong");
	property p_wait_max;
		wcnt_q <= (card_nonstorage ? 10'd750 : 10'd87);
	endproperty
	a_wait_max: assert property (p_wait_max) else $error("wait held too long");
	property p_lvl1;
		lvl1_active && ce |=> card_nonstorage;
	endproperty
	a_lvl1: assert property (p_lvl1) else $error("level 1 card still storage");
	c_feat: cover property (feat ##1 rsp.aborted);
	c_exec: cover property (exec_valid ##[1:20] rsp.done);
	c_wait: cover property (wcnt_q == 10'd86);
endmodule : sca_sva

bind sca_core sca_sva #(.SET_FEAT_OPC(SET_FEAT_OPC)) u_sca_sva (
	.clk_sys(clk_sys), .reset_n(reset_n), .ce(ce), .cmd_in(cmd_in),
	.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .exec_valid(exec_valid),
	.exec_op(exec_op), .rsp(rsp), .asleep(asleep), .wait_n(wait_n),
	.host_current(host_current), .lvl1_active(lvl1_active),
	.card_nonstorage(card_nonstorage), .cfg_base(cfg_base));

// >>> sim/sca_backend_model.sv
// Purpose: Backend that finishes passed-on commands
// Assumes: One command in flight at a time
// Notes:   Delay and error are set by the bench per command
module sca_backend_model (
	input  wire logic       clk_sys,
	input  wire logic       reset_n,
	input  wire logic       exec_valid,
	input  wire logic [3:0] dly,
	input  wire logic       fail,
	output logic            exec_done,
	output logic            exec_error
);
	timeunit 1ns;
	timeprecision 1ps;
	logic       busy_q;
	logic [3:0] cnt_q;
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			busy_q     <= 1'b0;
			cnt_q      <= 4'h0;
			exec_done  <= 1'b0;
			exec_error <= 1'b0;
		end else begin
			exec_done  <= 1'b0;
			// Error flag toggles every cycle except the done cycle so a stale value is never trusted
			exec_error <= ~exec_error;
			if (exec_valid) begin
				busy_q <= 1'b1;
				cnt_q  <= dly;
			end else if (busy_q && cnt_q == 4'h0) begin
				busy_q     <= 1'b0;
				exec_done  <= 1'b1;
				exec_error <= fail;
			end else if (busy_q) begin
				cnt_q <= cnt_q - 4'h1;
			end
		end
	end
endmodule : sca_backend_model

// >>> sim/tb_top.sv
// Purpose: Self-checking bench for the storage card command block
// Assumes: Storage card class, short idle step
// Notes:   ce is dropped once to check that it freezes the block
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import sca_pkg::*;
	// ==========================================================
	// Signals
	logic clk_sys = 0, reset_n = 0, cmd_valid = 0, sleep_enter = 0, idle_load = 0;
	logic wait_req = 0, lvl1_cfg_req = 0, fail = 0, ce = 1;
	logic cmd_ready, exec_valid, exec_done, exec_error, asleep, standby_req, wait_n;
	logic wait_cut, lvl1_active, card_nonstorage, mode_ok;
	logic [7:0]  idle_units = 8'h00, host_current;
	logic [3:0]  dly = 4'h0;
	logic [1:0]  mode_pin = 2'h0;
	logic [11:0] cfg_base;
	sca_cmd_t cmd_in = '0, exec_cmd;
	sca_op_t  exec_op;
	sca_rsp_t rsp;
	int err_count = 0, cmp_count = 0;
	always #2 clk_sys = ~clk_sys;
	sca_core #(.IDLE_STEP(8)) u_sca_core (.clk_sys(clk_sys), .reset_n(reset_n), .ce(ce),
		.cmd_in(cmd_in), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .exec_valid(exec_valid),
		.exec_op(exec_op), .exec_cmd(exec_cmd), .exec_done(exec_done), .exec_error(exec_error),
		.sleep_enter(sleep_enter), .rsp(rsp), .asleep(asleep), .idle_load(idle_load),
		.idle_units(idle_units), .standby_req(standby_req), .wait_req(wait_req),
		.wait_n(wait_n), .wait_cut(wait_cut), .lvl1_cfg_req(lvl1_cfg_req),
		.host_current(host_current), .lvl1_active(lvl1_active),
		.card_nonstorage(card_nonstorage), .cfg_base(cfg_base), .mode_pin(mode_pin),
		.mode_ok(mode_ok));
	sca_backend_model u_sca_backend_model (.clk_sys(clk_sys), .reset_n(reset_n),
		.exec_valid(exec_valid), .dly(dly), .fail(fail), .exec_done(exec_done),
		.exec_error(exec_error));
	// ==========================================================
	// Tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic test_done();
		$display("checks=%0d mismatches=%0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : test_done
	// Command is taken at the edge after it is driven; result read just after
	task automatic send(input logic [7:0] o, input logic [7:0] f, input logic [7:0] c);
		@(posedge clk_sys);
		cmd_valid <= 1'b1;
		cmd_in    <= '{o, f, c};
		@(posedge clk_sys);
		cmd_valid <= 1'b0;
		#1;
	endtask : send
	task automatic t_features();
		logic [7:0] tab [8] = '{8'h03, 8'h44, 8'haa, 8'h55, 8'h69, 8'h96, 8'h97, 8'h9a};
		foreach (tab[i]) begin
			send(8'hef, tab[i], 8'h01 + 8'(i));
			chk(rsp, {1'b1, i < 4});
		end
		chk(host_current, 8'h08);
		$display("features done");
	endtask : t_features
	// Clock enable low: a command on the bus must leave no trace
	task automatic t_ce();
		@(posedge clk_sys) ce <= 1'b0;
		send(8'hef, 8'h9a, 8'h55);
		chk({rsp, host_current}, {2'b00, 8'h08});
		@(posedge clk_sys) ce <= 1'b1;
		$display("clock enable done");
	endtask : t_ce
	task automatic t_opcodes();
		logic [7:0] opc [7] = '{8'hc0, 8'h87, 8'hf5, 8'h03, 8'h38, 8'hcd, 8'h20};
		sca_op_t    exp [7] = '{OP_ERASE, OP_TRANSLATE, OP_WEAR_LEVEL, OP_SENSE,
			OP_WR_NOERASE, OP_WRM_NOERASE, OP_BASELINE};
		int n;
		foreach (opc[i]) begin
			dly  <= 4'(i * 2);
			fail <= (i == 6);
			send(opc[i], 8'h00, 8'h01);
			chk({exec_valid, exec_op}, {1'b1, exp[i]});
			chk(exec_cmd, {opc[i], 8'h00, 8'h01});
			for (n = 0; n < 50 && !rsp.done; n++) @(posedge clk_sys) #1;
			if (n == 50) begin err_count++; test_done(); end
			chk(rsp.aborted, i == 6);
		end
		$display("opcodes done");
	endtask : t_opcodes
	task automatic t_sleep();
		@(posedge clk_sys) sleep_enter <= 1'b1;
		@(posedge clk_sys) sleep_enter <= 1'b0;
		#1 chk(asleep, 1'b1);
		send(8'hef, 8'h69, 8'h00);
		chk({asleep, rsp.done}, 2'b01);
		$display("sleep done");
	endtask : t_sleep
	task automatic t_idle();
		int n;
		@(posedge clk_sys) begin idle_load <= 1'b1; idle_units <= 8'h02; end
		@(posedge clk_sys) idle_load <= 1'b0;
		for (n = 0; n < 100 && !standby_req; n++) @(posedge clk_sys) #1;
		chk(n >= 14 && n <= 17, 1'b1);
		if (n == 100) test_done();
		$display("idle done");
	endtask : t_idle
	task automatic t_wait();
		int n = 0;
		@(posedge clk_sys) wait_req <= 1'b1;
		repeat (200) @(posedge clk_sys) #1 n += !wait_n;
		// Cut lands one cycle inside the 87 cycle ceiling
		chk(n, 86);
		chk(wait_cut, 1'b1);
		@(posedge clk_sys) wait_req <= 1'b0;
		$display("wait done");
	endtask : t_wait
	task automatic t_modes();
		for (int m = 0; m < 4; m++) begin
			@(posedge clk_sys) mode_pin <= 2'(m);
			repeat (4) @(posedge clk_sys);
			#1 chk(mode_ok, m < 3);
		end
		@(posedge clk_sys) mode_pin <= 2'h0;
		$display("modes done");
	endtask : t_modes
	task automatic t_lvl1();
		#1 chk({card_nonstorage, cfg_base}, {1'b0, 12'h200});
		send(8'hef, 8'h9a, 8'h00);
		@(posedge clk_sys) lvl1_cfg_req <= 1'b1;
		repeat (3) @(posedge clk_sys);
		#1 chk({lvl1_active, card_nonstorage}, 2'b00);
		send(8'hef, 8'h9a, 8'h01);
		repeat (3) @(posedge clk_sys);
		#1 chk({lvl1_active, card_nonstorage, cfg_base}, {2'b11, 12'h400});
		$display("level one done");
	endtask : t_lvl1
	// ==========================================================
	// Sequence
	initial begin
		repeat (10) @(posedge clk_sys);
		reset_n <= 1'b1;
		t_features();
		t_ce();
		t_opcodes();
		t_sleep();
		t_idle();
		t_wait();
		t_modes();
		t_lvl1();
		test_done();
	end
endmodule : tb_top
